/* File: hdl/cpu_defines.svh */
// Offsets, field positions, reset values and timing counts of the compare/PWM unit
`ifndef CPU_DEFINES_SVH
`define CPU_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register word offsets of the unit's 32-bit register port, one byte register per word
// ----------------------------------------------------------------------------
`define CPU_REG_CTRL        3'h0
`define CPU_REG_VAL_LOW     3'h1
`define CPU_REG_VAL_HIGH    3'h2
`define CPU_REG_TMR_SEL     3'h3
`define CPU_REG_PIN_RELOC   3'h4
`define CPU_REG_STATUS      3'h5

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define CPU_CTRL_EN_BIT     7
`define CPU_CTRL_FMT_BIT    4
`define CPU_CTRL_MODE_MSB   3
`define CPU_CTRL_MODE_LSB   0
`define CPU_TMR_SEL_MSB     1
`define CPU_RELOC_BIT       0
`define CPU_STAT_CMP_BIT    0
`define CPU_STAT_PWM_BIT    1
`define CPU_STAT_PIN_BIT    2

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define CPU_CTRL_RST        8'h00
`define CPU_VAL_RST         8'h00
`define CPU_TMR_SEL_RST     2'h0
`define CPU_RELOC_RST       1'b0
`define CPU_DUTY_RST        10'h000

// ----------------------------------------------------------------------------
// Timing counts: four system clocks per instruction cycle
// ----------------------------------------------------------------------------
`define CPU_INST_LAST_PHASE 2'h3
`define CPU_PS_1_1          2'h0
`define CPU_PS_1_4          2'h1
`define CPU_PS_1_16         2'h2
`define CPU_PS_4_LAST       4'h3
`define CPU_PS_16_LAST      4'hf
`define CPU_TB_PS_1         2'h0
`define CPU_TB_PS_2         2'h1
`define CPU_TB_PS_4         2'h2
`define CPU_TB_PS_8         2'h3

`endif

/* File: hdl/cpu_pkg.sv */
// Types shared by both ends of the compare/PWM unit
package cpu_pkg;

	// ------------------------------------------------------------------------
	// Operating modes of the unit
	// ------------------------------------------------------------------------
	typedef enum logic [3:0] {
		CPU_MODE_OFF     = 4'h0,
		CPU_MODE_TOG     = 4'h1,
		CPU_MODE_TOG2    = 4'h2,
		CPU_MODE_SET     = 4'h8,
		CPU_MODE_CLR     = 4'h9,
		CPU_MODE_SWEVT   = 4'ha,
		CPU_MODE_PULSE   = 4'hb,
		CPU_MODE_PWM     = 4'hc,
		CPU_MODE_PWM_D   = 4'hd,
		CPU_MODE_PWM_E   = 4'he,
		CPU_MODE_PWM_F   = 4'hf
	} cpu_mode_e;

	typedef logic [7:0]       cpu_byte_t;
	typedef logic [9:0]       cpu_duty_t;
	typedef logic [2:0][7:0]  cpu_cnt8_t;
	typedef logic [2:0][1:0]  cpu_lo2_t;

endpackage

/* File: hdl/cpu_link_if.sv */
// Link between the timer end and the compare/PWM unit end
`timescale 1ns/1ns
interface cpu_link_if;
	import cpu_pkg::*;

	logic [15:0] tb_count;  // Compare timebase count, high:low
	cpu_cnt8_t   pwm_cnt;   // Count of each 8-bit auto-reload timer
	cpu_lo2_t    pwm_lo2;   // Two low bits of each 10-bit time base
	logic [2:0]  pwm_roll;  // One-cycle pulse: timer just rolled over
	logic        cmp_out;   // Compare output, fed back as timer reset

	modport unit (
		input  tb_count,
		input  pwm_cnt,
		input  pwm_lo2,
		input  pwm_roll,
		output cmp_out
	);

	modport timers (
		output tb_count,
		output pwm_cnt,
		output pwm_lo2,
		output pwm_roll,
		input  cmp_out
	);
endinterface // cpu_link_if

/* File: hdl/cpu_timer_end.sv */
// Timer end: compare timebase and three 8-bit auto-reload PWM timers
`timescale 1ns/1ns
`include "cpu_defines.svh"
module cpu_timer_end
	import cpu_pkg::*;
(
	// Clock, reset, enable
	input  wire logic       hclk,
	input  wire logic       hresetn,
	input  wire logic       ce,
	// Compare timebase control
	input  wire logic       tb_run,
	input  wire logic [1:0] tb_prescale,
	input  wire logic       tb_wr,
	input  wire logic [15:0] tb_wdata,
	// PWM timer control
	input  wire logic [2:0] pwm_run,
	input  wire cpu_cnt8_t  pwm_period,
	input  wire cpu_lo2_t   pwm_prescale,
	input  wire logic [2:0] pwm_ext_rst_en,
	// Link to the unit
	cpu_link_if.timers      link
);

	// ------------------------------------------------------------------------
	// Instruction clock phase: system clock divided by four
	// ------------------------------------------------------------------------
	logic [1:0]  phase_q;
	logic        inst_tick;
	logic [2:0]  tb_ps_q;
	logic [15:0] tb_q;
	logic        cmp_prev_q;
	logic        cmp_rise;
	logic        tb_inc;
	logic [2:0]  tb_ps_last;

	assign inst_tick = (phase_q == `CPU_INST_LAST_PHASE);
	assign cmp_rise  = link.cmp_out & ~cmp_prev_q;
	assign tb_ps_last = (3'h1 << tb_prescale) - 3'h1;
	assign tb_inc    = tb_run & inst_tick & (tb_ps_q == tb_ps_last);

	// Phase counter and compare output edge history
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			phase_q    <= 2'h0;
			cmp_prev_q <= 1'b0;
		end else if (ce) begin
			phase_q    <= phase_q + 2'h1;
			cmp_prev_q <= link.cmp_out;
		end
	end

	// Compare timebase: synchronous timer mode only, stepped by the instruction clock
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tb_ps_q <= 3'h0;
			tb_q    <= 16'h0000;
		end else if (ce) begin
			if (tb_wr) begin
				tb_q    <= tb_wdata;
				tb_ps_q <= 3'h0;
			end else if (tb_run && inst_tick) begin
				tb_ps_q <= tb_inc ? 3'h0 : tb_ps_q + 3'h1;
				if (tb_inc)
					tb_q <= tb_q + 16'h0001;
			end
		end
	end

	assign link.tb_count = tb_q;

	// ------------------------------------------------------------------------
	// PWM timers; the postscaler is absent, period set by pwm_period and prescale
	// ------------------------------------------------------------------------
	for (genvar i = 0; i < 3; i++) begin : g_pwm
		logic [3:0] ps_q;
		logic [7:0] cnt_q;
		logic       roll_q;
		logic [3:0] ps_last;
		logic       inc;
		logic       ext_rst;

		assign ps_last = (pwm_prescale[i] == `CPU_PS_1_16) ? `CPU_PS_16_LAST :
		                 (pwm_prescale[i] == `CPU_PS_1_4)  ? `CPU_PS_4_LAST : 4'h0;
		assign inc     = pwm_run[i] & inst_tick & (ps_q == ps_last);
		assign ext_rst = pwm_ext_rst_en[i] & cmp_rise;

		// Prescaler, count and rollover pulse; cleared on the increment after the period match
		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn) begin
				ps_q   <= 4'h0;
				cnt_q  <= 8'h00;
				roll_q <= 1'b0;
			end else if (ce) begin
				roll_q <= inc & (cnt_q == pwm_period[i]) & ~ext_rst;
				if (ext_rst) begin
					ps_q  <= 4'h0;
					cnt_q <= 8'h00;
				end else if (pwm_run[i] && inst_tick) begin
					ps_q <= inc ? 4'h0 : ps_q + 4'h1;
					if (inc)
						cnt_q <= (cnt_q == pwm_period[i]) ? 8'h00 : cnt_q + 8'h01;
				end
			end
		end

		// Low bits: clock phase at 1:1, otherwise the top prescaler bits
		assign link.pwm_lo2[i]  = (pwm_prescale[i] == `CPU_PS_1_16) ? ps_q[3:2] :
		                          (pwm_prescale[i] == `CPU_PS_1_4)  ? ps_q[1:0] : phase_q;
		assign link.pwm_cnt[i]  = cnt_q;
		assign link.pwm_roll[i] = roll_q;
	end

endmodule // cpu_timer_end

/* File: hdl/cpu_unit_end.sv */
// Compare/PWM unit end: compare matching, PWM generation and register port
`timescale 1ns/1ns
`include "cpu_defines.svh"

module cpu_unit_end
	import cpu_pkg::*;
(
	// Clock, reset, enable
	input  wire logic       hclk,
	input  wire logic       hresetn,
	input  wire logic       ce,
	// AHB-Lite slave port
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	// Internal taps of the compare output, and the match event
	output logic            cwg_in,
	output logic            adc_trig,
	output logic            smt_window,
	output logic            clc_in,
	output logic            match_evt,
	// Output pin, default and alternate location
	output logic            pin0_out,
	output logic            pin0_oe,
	output logic            pin1_out,
	output logic            pin1_oe,
	// Link to the timers
	cpu_link_if.unit        link
);

	// ------------------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------------------

	// Assemble the 10-bit duty value from the register pair
	function automatic cpu_duty_t duty_of(input logic fmt, input cpu_byte_t hi, input cpu_byte_t lo);
		duty_of = fmt ? {hi, lo[7:6]} : {hi[1:0], lo};
	endfunction

	// True for the four PWM mode codes
	function automatic logic is_pwm(input logic [3:0] m);
		is_pwm = (m[3:2] == 2'b11);
	endfunction

	// ------------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------------
	cpu_byte_t  ctrl_q;
	cpu_byte_t  val_low_q;
	cpu_byte_t  val_high_q;
	logic [1:0] tmr_sel_q;
	logic       reloc_q;
	cpu_byte_t  rdata_q;
	logic       dph_wr_q;
	logic       dph_rd_q;
	logic       rd_done_q;
	logic [2:0] dph_idx_q;
	cpu_duty_t  duty_latch_q;
	logic       cmp_q;
	logic       pwm_q;
	logic       eq_q;
	logic       evt_q;

	// ------------------------------------------------------------------------
	// Decoding
	// ------------------------------------------------------------------------
	// Bus transfers: aligned words inside the register window only
	wire        addr_ok   = (haddr[31:5] == 27'h0000000) & (haddr[1:0] == 2'h0);
	wire        bus_take  = hsel & htrans[1] & hready & (hsize == 3'h2) & addr_ok;
	wire        rd_stall  = dph_rd_q & ~rd_done_q;
	wire        wr_ctrl   = dph_wr_q & (dph_idx_q == `CPU_REG_CTRL);
	wire        wr_low    = dph_wr_q & (dph_idx_q == `CPU_REG_VAL_LOW);
	wire        wr_high   = dph_wr_q & (dph_idx_q == `CPU_REG_VAL_HIGH);
	wire        wr_tsel   = dph_wr_q & (dph_idx_q == `CPU_REG_TMR_SEL);
	wire        wr_reloc  = dph_wr_q & (dph_idx_q == `CPU_REG_PIN_RELOC);
	wire        enabled   = ctrl_q[`CPU_CTRL_EN_BIT];
	wire        fmt       = ctrl_q[`CPU_CTRL_FMT_BIT];
	wire [3:0]  mode      = enabled ? ctrl_q[`CPU_CTRL_MODE_MSB:`CPU_CTRL_MODE_LSB] : CPU_MODE_OFF;
	wire        pwm_mode  = is_pwm(mode);
	wire        cmp_mode  = (mode != CPU_MODE_OFF) & ~pwm_mode;

	// Compare match against the 16-bit timebase
	wire [15:0] cmp_val   = {val_high_q, val_low_q};
	wire        eq        = cmp_mode & (link.tb_count == cmp_val);
	wire        eq_rise   = eq & ~eq_q;

	// Mode decode of the compare actions
	wire        mode_pulse = (mode == CPU_MODE_PULSE) | (mode == CPU_MODE_SWEVT);
	wire        mode_tog   = (mode == CPU_MODE_TOG) | (mode == CPU_MODE_TOG2);
	wire        mode_set   = (mode == CPU_MODE_SET);
	wire        mode_clr   = (mode == CPU_MODE_CLR);

	// Selected PWM timer and the 10-bit time base
	wire        tsel_ok   = (tmr_sel_q != 2'h3);
	wire [1:0]  tsel      = tsel_ok ? tmr_sel_q : 2'h0;
	wire [9:0]  pwm_base  = {link.pwm_cnt[tsel], link.pwm_lo2[tsel]};
	wire        pwm_roll  = link.pwm_roll[tsel];
	wire [9:0]  duty_next = duty_of(fmt, val_high_q, val_low_q);

	// Pin control: software event mode never takes the pin
	wire        pin_owned = pwm_mode | (cmp_mode & (mode != CPU_MODE_SWEVT));
	wire        pin_level = pwm_mode ? pwm_q : cmp_q;

	// ------------------------------------------------------------------------
	// Register file; duty bytes share the compare value pair and are always writable
	// ------------------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_q     <= `CPU_CTRL_RST;
			val_low_q  <= `CPU_VAL_RST;
			val_high_q <= `CPU_VAL_RST;
			tmr_sel_q  <= `CPU_TMR_SEL_RST;
			reloc_q    <= `CPU_RELOC_RST;
		end else if (ce) begin
			if (wr_ctrl)
				ctrl_q <= hwdata[7:0];
			if (wr_low)
				val_low_q <= hwdata[7:0];
			if (wr_high)
				val_high_q <= hwdata[7:0];
			if (wr_tsel)
				tmr_sel_q <= hwdata[`CPU_TMR_SEL_MSB:0];
			if (wr_reloc)
				reloc_q <= hwdata[`CPU_RELOC_BIT];
		end
	end

	// Address phase capture; a read waits one cycle so that a write just before it has landed
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dph_wr_q  <= 1'b0;
			dph_rd_q  <= 1'b0;
			dph_idx_q <= 3'h0;
			rd_done_q <= 1'b0;
		end else if (ce) begin
			if (hready) begin
				dph_wr_q  <= bus_take & hwrite;
				dph_rd_q  <= bus_take & ~hwrite;
				dph_idx_q <= haddr[4:2];
			end
			rd_done_q <= rd_stall;
		end
	end

	// Read data, registered in the wait cycle of the data phase; status shows live state
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rdata_q <= 8'h00;
		end else if (ce && rd_stall) begin
			unique case (dph_idx_q)
				`CPU_REG_CTRL:      rdata_q <= ctrl_q;
				`CPU_REG_VAL_LOW:   rdata_q <= val_low_q;
				`CPU_REG_VAL_HIGH:  rdata_q <= val_high_q;
				`CPU_REG_TMR_SEL:   rdata_q <= {6'h00, tmr_sel_q};
				`CPU_REG_PIN_RELOC: rdata_q <= {7'h00, reloc_q};
				`CPU_REG_STATUS:    rdata_q <= {5'h00, pin_level, pwm_q, cmp_q};
				default:            rdata_q <= 8'h00;
			endcase
		end
	end

	// ------------------------------------------------------------------------
	// Compare output; stops with the clock, so nothing matches in sleep
	// ------------------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cmp_q <= 1'b0;
			eq_q  <= 1'b0;
			evt_q <= 1'b0;
		end else if (ce) begin
			eq_q  <= eq;
			evt_q <= eq_rise;
			if (mode_pulse)
				cmp_q <= eq;
			else if (mode_tog && eq_rise)
				cmp_q <= ~cmp_q;
			else if (mode_set && eq_rise)
				cmp_q <= 1'b1;
			else if (mode_clr && eq_rise)
				cmp_q <= 1'b0;
		end
	end

	// ------------------------------------------------------------------------
	// PWM: duty latched at rollover, pin set at rollover unless the duty is zero, cleared at duty match
	// ------------------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			duty_latch_q <= `CPU_DUTY_RST;
			pwm_q        <= 1'b0;
		end else if (ce) begin
			if (!pwm_mode) begin
				pwm_q <= 1'b0;
			end else if (pwm_roll) begin
				duty_latch_q <= duty_next;
				pwm_q        <= (duty_next != 10'h000);
			end else if (pwm_base == duty_latch_q) begin
				pwm_q <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------------
	assign hrdata       = {24'h000000, rdata_q};
	assign hreadyout    = ~rd_stall;
	assign hresp        = 1'b0;
	assign link.cmp_out = cmp_q;
	assign cwg_in       = cmp_q;
	assign adc_trig     = cmp_q;
	assign smt_window   = cmp_q;
	assign clc_in       = cmp_q;
	assign match_evt    = evt_q;

	// Pin location follows the relocation bit
	assign pin0_out = pin_level & ~reloc_q;
	assign pin0_oe  = pin_owned & ~reloc_q;
	assign pin1_out = pin_level & reloc_q;
	assign pin1_oe  = pin_owned & reloc_q;

endmodule // cpu_unit_end

/* File: tb/cpu_link_props.sv */
// Concurrent checks on the link, the compare taps and the output pins
`timescale 1ns/1ns
module cpu_link_props
	import cpu_pkg::*;
(
	// Clock, reset, enable
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        ce,
	// Link signals
	input wire logic [15:0] tb_count,
	input wire cpu_cnt8_t   pwm_cnt,
	input wire cpu_lo2_t    pwm_lo2,
	input wire logic [2:0]  pwm_roll,
	input wire logic        cmp_out,
	// Unit taps and pins
	input wire logic        match_evt,
	input wire logic        cwg_in,
	input wire logic        adc_trig,
	input wire logic        smt_window,
	input wire logic        clc_in,
	input wire logic        pin0_out,
	input wire logic        pin0_oe,
	input wire logic        pin1_out,
	input wire logic        pin1_oe
);
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	// ----------------
	// Properties
	// ----------------
	// Timer 1 stays quiet for eight clocks after its roll
	sequence s_quiet1;
		!pwm_roll[1] [*8];
	endsequence
	property p_taps;
		{cwg_in, adc_trig, smt_window, clc_in} == {4{cmp_out}};
	endproperty
	property p_evt;
		$rose(cmp_out) |-> match_evt;
	endproperty
	property p_reloc;
		pin1_oe |-> !pin0_oe;
	endproperty
	property p_rst;
		$rose(hresetn) |-> !cmp_out && !pin0_out && !pin1_out && !match_evt;
	endproperty
	// A frozen clock enable stops every count
	property p_ce;
		!ce |=> $stable(tb_count) && $stable(pwm_cnt);
	endproperty
	property p_lo2;
		ce && hresetn |=> pwm_lo2[0] == $past(pwm_lo2[0]) + 2'h1;
	endproperty
	property p_roll_clr;
		pwm_roll[1] |-> pwm_cnt[1] == 8'h00;
	endproperty
	property p_roll_gap;
		pwm_roll[1] |=> s_quiet1;
	endproperty
	// The pin only rises after a roll or with the compare output
	property p_pin_rise;
		$rose(pin0_out) |-> $past(pwm_roll) != 3'h0 || cmp_out;
	endproperty

	// ----------------
	// Assertions
	// ----------------
	a_taps: assert property (p_taps) else $error("compare taps differ from output");
	a_evt: assert property (p_evt) else $error("output rose without match event");
	a_reloc: assert property (p_reloc) else $error("both pin locations driven");
	a_rst: assert property (p_rst) else $error("outputs not low after reset");
	a_ce: assert property (p_ce) else $error("count moved while frozen");
	a_lo2: assert property (p_lo2) else $error("low base bits not stepping");
	a_roll_clr: assert property (p_roll_clr) else $error("timer not cleared at roll");
	a_roll_gap: assert property (p_roll_gap) else $error("roll period too short");
	a_pin_rise: assert property (p_pin_rise) else $error("pin rose without cause");
endmodule // cpu_link_props

/* File: tb/tb_top.sv */
// Bench joining the timer end and the unit end, driven through the register port
`timescale 1ns/1ns
`include "cpu_defines.svh"
module tb_top
	import cpu_pkg::*;
	;
	// Clock, reset and timer controls
	logic        hclk           = 1'b0;
	logic        hresetn        = 1'b0;
	logic        ce             = 1'b1;
	logic        tb_run         = 1'b0;
	logic        tb_wr          = 1'b0;
	logic [15:0] tb_wdata       = 16'h0000;
	logic [1:0]  tb_prescale    = 2'h0;
	logic [2:0]  pwm_run        = 3'h7;
	cpu_cnt8_t   pwm_period     = {8'h01, 8'h02, 8'h00};
	cpu_lo2_t    pwm_prescale   = {2'h1, 2'h0, 2'h0};
	logic [2:0]  pwm_ext_rst_en = 3'h0;
	// AHB-Lite master signals and unit outputs
	logic        hsel      = 1'b0;
	logic [31:0] haddr     = 32'h00000000;
	logic [1:0]  htrans    = 2'h0;
	logic        hwrite    = 1'b0;
	logic [2:0]  hsize     = 3'h0;
	logic [31:0] hwdata    = 32'h00000000;
	logic [31:0] hrdata;
	logic        hreadyout, hresp;
	logic        cwg_in, adc_trig, smt_window, clc_in, match_evt;
	logic        pin0_out, pin0_oe, pin1_out, pin1_oe;
	int          num_errors = 0;
	int          n_checks   = 0;
	int          cyc        = 0;
	// Compare modes, level at the match and eight clocks later
	cpu_mode_e   modes [6]  = '{CPU_MODE_SET, CPU_MODE_TOG, CPU_MODE_TOG2,
		CPU_MODE_CLR, CPU_MODE_PULSE, CPU_MODE_SWEVT};
	bit          ex_in [6]  = '{1, 0, 1, 0, 1, 1};
	bit          ex_af [6]  = '{1, 0, 1, 0, 0, 0};
	// PWM cases: alignment, duty bytes, high time and period in clocks
	bit          fm [3]     = '{0, 1, 0};
	cpu_byte_t   dh [3]     = '{8'h00, 8'h01, 8'h00};
	cpu_byte_t   dl [3]     = '{8'h02, 8'h40, 8'h03};
	int          hi [3]     = '{2, 5, 12};
	int          pr [3]     = '{4, 12, 32};

	// Both ends, their link and the checker
	cpu_link_if cpu_link_if_inst ();
	wire logic [15:0] tb_cnt  = cpu_link_if_inst.tb_count;
	wire logic        cmp_lvl = cpu_link_if_inst.cmp_out;
	cpu_timer_end cpu_timer_end_inst (.hclk(hclk), .hresetn(hresetn), .ce(ce), .tb_run(tb_run),
		.tb_prescale(tb_prescale), .tb_wr(tb_wr), .tb_wdata(tb_wdata), .pwm_run(pwm_run),
		.pwm_period(pwm_period), .pwm_prescale(pwm_prescale), .pwm_ext_rst_en(pwm_ext_rst_en),
		.link(cpu_link_if_inst.timers));
	cpu_unit_end cpu_unit_end_inst (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.cwg_in(cwg_in), .adc_trig(adc_trig), .smt_window(smt_window), .clc_in(clc_in),
		.match_evt(match_evt), .pin0_out(pin0_out), .pin0_oe(pin0_oe), .pin1_out(pin1_out),
		.pin1_oe(pin1_oe), .link(cpu_link_if_inst.unit));
	cpu_link_props cpu_link_props_inst (.hclk(hclk), .hresetn(hresetn), .ce(ce),
		.tb_count(cpu_link_if_inst.tb_count), .pwm_cnt(cpu_link_if_inst.pwm_cnt),
		.pwm_lo2(cpu_link_if_inst.pwm_lo2), .pwm_roll(cpu_link_if_inst.pwm_roll),
		.cmp_out(cpu_link_if_inst.cmp_out), .match_evt(match_evt), .cwg_in(cwg_in),
		.adc_trig(adc_trig), .smt_window(smt_window), .clc_in(clc_in), .pin0_out(pin0_out),
		.pin0_oe(pin0_oe), .pin1_out(pin1_out), .pin1_oe(pin1_oe));

	// Clock and clock counter
	always #2 hclk = ~hclk;
	always @(posedge hclk) cyc <= cyc + 1;

	// Compare and count
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Counts a timed out wait as a mismatch and ends the run
	task automatic expire;
		num_errors++;
		$display("MISMATCH at %0t: wait timed out", $time);
		final_report();
	endtask
	// AHB-Lite single word transfer: address phase, then data phase, each held until hready
	task automatic xfer(input bit w, input logic [2:0] a, input cpu_byte_t d, output cpu_byte_t q);
		int n;
		q = 8'h00;
		@(posedge hclk);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr  <= {27'h0000000, a, 2'h0};
		hsize  <= 3'h2;
		for (int ph = 0; ph < 2; ph++) begin
			for (n = 0; n < 50; n++) begin
				@(posedge hclk);
				if (hreadyout === 1'b1) break;
			end
			if (n == 50) expire();
			if (ph == 0) begin
				hsel   <= 1'b0;
				htrans <= 2'h0;
				hwdata <= {24'h000000, d};
			end
		end
		q = hrdata[7:0];
	endtask
	task automatic wr(input logic [2:0] a, input cpu_byte_t d);
		cpu_byte_t q;
		xfer(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [2:0] a, input cpu_byte_t exp);
		cpu_byte_t q;
		xfer(1'b0, a, 8'h00, q);
		chk(q, exp);
		chk(hresp, 1'b0);
	endtask
	// Bounded wait for the pin or the match event to reach a level
	task automatic wt(input bit s, input logic lvl);
		int n;
		for (n = 0; n < 400; n++) begin
			@(posedge hclk);
			#1;
			if ((s ? match_evt : pin0_out) === lvl) break;
		end
		if (n == 400) expire();
	endtask
	// Times one pulse and period, optionally rewriting the duty mid-pulse
	task automatic meas(input bit dw, input cpu_byte_t nlo, input int h, input int p);
		int t0;
		int t1;
		wt(0, 1'b0);
		wt(0, 1'b1);
		t0 = cyc;
		if (dw) wr(`CPU_REG_VAL_LOW, nlo);
		wt(0, 1'b0);
		t1 = cyc;
		wt(0, 1'b1);
		chk(16'(t1 - t0), 16'(h));
		chk(16'(cyc - t0), 16'(p));
	endtask

	// Main sequence
	initial begin
		int n;
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		wr(`CPU_REG_STATUS, 8'hff);
		wr(3'h6, 8'hff);
		#1 chk({cmp_lvl, pin0_out, pin0_oe, pin1_out, pin1_oe}, 16'h0000);
		for (int a = 0; a < 7; a++) rd(3'(a), 8'h00);
		$display("test reset done");
		// Match value 0x0020 from a start count of 0x001e in every compare mode
		wr(`CPU_REG_VAL_LOW, 8'h20);
		wr(`CPU_REG_VAL_HIGH, 8'h00);
		for (int i = 0; i < 6; i++) begin
			@(posedge hclk);
			tb_run   <= 1'b0;
			tb_wr    <= 1'b1;
			tb_wdata <= 16'h001e;
			@(posedge hclk);
			tb_wr <= 1'b0;
			wr(`CPU_REG_CTRL, {4'h8, modes[i]});
			@(posedge hclk);
			tb_run <= 1'b1;
			ce     <= 1'b0;
			repeat (6) @(posedge hclk);
			ce <= 1'b1;
			#1 chk(tb_cnt, 16'h001e);
			wt(1, 1'b1);
			chk(tb_cnt, 16'h0020);
			chk(cmp_lvl, ex_in[i]);
			chk(pin0_oe, modes[i] != CPU_MODE_SWEVT);
			if (modes[i] != CPU_MODE_SWEVT) chk(pin0_out, ex_in[i]);
			repeat (8) @(posedge hclk);
			#1 chk(cmp_lvl, ex_af[i]);
			if (i == 0) rd(`CPU_REG_STATUS, 8'h05);
		end
		$display("test compare done");
		// Pin moved to the alternate location and back
		wr(`CPU_REG_CTRL, 8'h88);
		wr(`CPU_REG_PIN_RELOC, 8'h01);
		#1 chk({pin1_oe, pin0_oe, pin1_out, pin0_out}, 4'b1000);
		wr(`CPU_REG_PIN_RELOC, 8'h00);
		#1 chk({pin1_oe, pin0_oe}, 2'b01);
		$display("test pins done");
		// Each timer, both alignments, then a duty change mid-pulse
		for (int i = 0; i < 3; i++) begin
			wr(`CPU_REG_TMR_SEL, 8'(i));
			wr(`CPU_REG_CTRL, fm[i] ? 8'h9c : 8'h8c);
			wr(`CPU_REG_VAL_HIGH, dh[i]);
			wr(`CPU_REG_VAL_LOW, dl[i]);
			meas(1'b0, 8'h00, hi[i], pr[i]);
		end
		meas(1'b1, 8'h07, 12, 32);
		meas(1'b0, 8'h00, 28, 32);
		// Zero duty keeps the pin low
		wr(`CPU_REG_VAL_LOW, 8'h00);
		repeat (40) @(posedge hclk);
		n = 0;
		repeat (64) begin
			@(posedge hclk);
			#1 n += (pin0_out !== 1'b0);
		end
		chk(16'(n), 16'h0000);
		$display("test pwm done");
		final_report();
	end
endmodule // tb_top
